// *** axil_reg_port.sv ***
`timescale 1ns/100ps
module axil_reg_port (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [power_mode_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [power_mode_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output power_mode_pkg::wr_req_t wr_req,
	input wire logic wr_err,
	output power_mode_pkg::rd_req_t rd_req,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);

	logic [power_mode_pkg::ADDR_W-1:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [power_mode_pkg::ADDR_W-1:0] raddr_r;
	logic wr_fire;
	logic rd_fire;

	// ----------------------------------------
	// Write channels
	// ----------------------------------------
	assign wr_fire = !awready && !wready && !bvalid;
	assign wr_req = '{valid: wr_fire, addr: waddr_r, data: wdata_r, strb: wstrb_r};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= power_mode_pkg::RESP_OKAY;
			waddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				waddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_err ? power_mode_pkg::RESP_SLVERR : power_mode_pkg::RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read channels
	// ----------------------------------------
	assign rd_fire = !arready && !rvalid;
	assign rd_req = '{valid: rd_fire, addr: raddr_r};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= power_mode_pkg::RESP_OKAY;
			raddr_r <= '0;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				raddr_r <= araddr;
			end
			if (rd_fire) begin
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rd_err ? power_mode_pkg::RESP_SLVERR : power_mode_pkg::RESP_OKAY;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

// *** clock_gate_map.sv ***
`timescale 1ns/100ps
module clock_gate_map (
	input power_mode_pkg::mode_t mode,
	input wire logic slow_xtal_on,
	input wire logic slow_rc_on,
	input wire logic [1:0] timer_src,
	input wire logic [1:0] watchdog_src,
	input wire logic pwm_src_slow_xtal,
	output power_mode_pkg::clk_gate_t gate
);

	// Low-speed source still alive while the fast clocks are halted
	function automatic logic slow_src_alive(input logic [1:0] sel, input logic xtal,
			input logic rc);
		slow_src_alive = (sel == power_mode_pkg::SRC_SLOW_XTAL && xtal) ||
			(sel == power_mode_pkg::SRC_SLOW_RC && rc);
	endfunction

	always_comb begin
		gate = power_mode_pkg::GATE_ALL_ON;
		case (mode)
			power_mode_pkg::MODE_RUN: begin
				gate = power_mode_pkg::GATE_ALL_ON;
			end
			power_mode_pkg::MODE_IDLE: begin
				gate.core = 1'b0;
			end
			power_mode_pkg::MODE_DEEP, power_mode_pkg::MODE_WAKE: begin
				gate = '0;
				gate.regulator = 1'b1;
				gate.sram_retention = 1'b1;
				gate.low_speed_crystal = slow_xtal_on;
				gate.low_speed_rc_osc = slow_rc_on;
				gate.timer = slow_src_alive(timer_src, slow_xtal_on, slow_rc_on);
				gate.watchdog_unit = slow_src_alive(watchdog_src, slow_xtal_on, slow_rc_on);
				gate.pwm = pwm_src_slow_xtal && slow_xtal_on;
				gate.rtc = slow_xtal_on;
				if (mode == power_mode_pkg::MODE_WAKE) begin
					gate.high_speed_crystal = 1'b1;
					gate.high_speed_rc_osc = 1'b1;
					gate.pll = 1'b1;
				end
			end
			default: begin
				gate = power_mode_pkg::GATE_ALL_ON;
			end
		endcase
	end

endmodule

// *** core_wake_model.sv ***
`timescale 1ns/100ps
module core_wake_model (
	input wire logic aclk,
	input wire logic aresetn,
	input power_mode_pkg::mode_t power_mode,
	input wire logic cmd_wait,
	input wire logic cmd_wake,
	input wire logic cmd_irq,
	input wire logic [4:0] cmd_bit,
	input wire logic [7:0] cmd_dly,
	output logic wait_for_interrupt_instr,
	output logic [31:0] irq_pending,
	output logic [7:0] pd_wake_req
);
	logic [7:0] cnt_r;
	logic armed_r;
	logic irq_sel_r;
	logic [4:0] bit_r;
	logic asleep;
	assign asleep = (power_mode == power_mode_pkg::MODE_IDLE) ||
		(power_mode == power_mode_pkg::MODE_DEEP);
	// One-cycle wait pulse, issued after software has set the enables
	always_ff @(posedge aclk) begin
		wait_for_interrupt_instr <= aresetn && cmd_wait;
	end
	// Wake source raised after a delay, held until the core leaves sleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_r <= 1'b0;
			cnt_r <= 8'h00;
			irq_pending <= '0;
			pd_wake_req <= '0;
		end else begin
			if (!asleep) begin
				irq_pending <= '0;
				pd_wake_req <= '0;
			end
			if (cmd_wake) begin
				armed_r <= 1'b1;
				cnt_r <= cmd_dly;
				irq_sel_r <= cmd_irq;
				bit_r <= cmd_bit;
			end else if (armed_r && cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end else if (armed_r) begin
				armed_r <= 1'b0;
				if (irq_sel_r) irq_pending[bit_r] <= 1'b1;
				else pd_wake_req[bit_r[2:0]] <= 1'b1;
			end
		end
	end
endmodule

// *** power_mode_clock_gating.sv ***
`timescale 1ns/100ps
// What this block does
// - After reset the chip is in Normal mode with the core and every clock running.
// - A wait instruction without power-down requested puts the core to sleep in Idle.
// - Power-down is entered only on a wait instruction with both enables set.
// - Idle wakes on any interrupt; Power-down only on the eight listed wake sources.
// - Power-down stops all clocks but the low-speed oscillators and the timer, PWM, watchdog and RTC they can feed, and keeps SRAM.
// - A valid wake-up from Idle or Power-down returns the core to Normal mode.
// - In Power-down each low-speed oscillator follows its software on/off setting.
// - In Power-down the timer runs only from a running low-speed oscillator.
// - In Power-down the PWM runs only from a running low-speed crystal.
// - In Power-down the watchdog runs only from a running low-speed oscillator.
// - In Power-down the real-time clock runs only while the low-speed crystal is on.
// - Power-down halts fast oscillators, PLL, core, buses and peripherals, not the regulator.
// - Idle gates only the core clock.
// - Sleep enable is control bit 8, power-down enable bit 7; both needed for Power-down.
module power_mode_clock_gating (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [power_mode_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [power_mode_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic wait_for_interrupt_instr,
	input wire logic [31:0] irq_pending,
	input wire logic [power_mode_pkg::WAKE_SRC_N-1:0] pd_wake_req,
	output power_mode_pkg::mode_t power_mode,
	output power_mode_pkg::clk_gate_t clk_gate
);

	power_mode_pkg::wr_req_t wr_req;
	power_mode_pkg::rd_req_t rd_req;
	logic wr_err;
	logic rd_err;
	logic [31:0] rd_data;

	logic [31:0] ctrl_r;
	logic [31:0] clksel_r;
	logic [power_mode_pkg::WAKE_IRQ_BIT:0] wake_flag_r;
	logic [power_mode_pkg::WAKE_IRQ_BIT:0] wake_set;
	logic [power_mode_pkg::WAKE_IRQ_BIT:0] wake_clr;
	power_mode_pkg::mode_t mode_r;
	power_mode_pkg::mode_t mode_nxt;
	logic [power_mode_pkg::SETTLE_W-1:0] settle_r;
	logic [power_mode_pkg::SETTLE_W-1:0] settle_nxt;
	power_mode_pkg::clk_gate_t gate_nxt;
	power_mode_pkg::clk_gate_t gate_r;
	logic deep_req;
	logic idle_wake;
	logic deep_wake;
	logic restart_busy;
	logic wr_ctrl;
	logic wr_clksel;
	logic wr_wake;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		merge_strb = res & mask;
	endfunction

	function automatic logic reg_hit(input logic [power_mode_pkg::ADDR_W-1:0] a);
		reg_hit = (a == power_mode_pkg::CTRL_OFS) || (a == power_mode_pkg::CLKSEL_OFS) ||
			(a == power_mode_pkg::STATUS_OFS) || (a == power_mode_pkg::WAKE_OFS);
	endfunction

	function automatic logic wr_hit(input power_mode_pkg::wr_req_t req,
			input logic [power_mode_pkg::ADDR_W-1:0] ofs);
		wr_hit = req.valid && (req.addr == ofs);
	endfunction

	// ----------------------------------------
	// Bus port
	// ----------------------------------------
	axil_reg_port u_port (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_req(wr_req),
		.wr_err(wr_err),
		.rd_req(rd_req),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	assign wr_err = !reg_hit(wr_req.addr);
	assign rd_err = !reg_hit(rd_req.addr);

	// ----------------------------------------
	// Write decode
	// ----------------------------------------

	assign wr_ctrl = wr_hit(wr_req, power_mode_pkg::CTRL_OFS);
	assign wr_clksel = wr_hit(wr_req, power_mode_pkg::CLKSEL_OFS);
	assign wr_wake = wr_hit(wr_req, power_mode_pkg::WAKE_OFS);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rd_data = '0;
		case (rd_req.addr)
			power_mode_pkg::CTRL_OFS: begin
				rd_data = ctrl_r;
			end
			power_mode_pkg::CLKSEL_OFS: begin
				rd_data = clksel_r;
			end
			power_mode_pkg::STATUS_OFS: begin
				rd_data[1:0] = mode_r;
				rd_data[power_mode_pkg::STAT_BUSY_BIT] = restart_busy;
			end
			power_mode_pkg::WAKE_OFS: begin
				rd_data[power_mode_pkg::WAKE_IRQ_BIT:0] = wake_flag_r;
			end
			default: begin
				rd_data = '0;
			end
		endcase
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= power_mode_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= merge_strb(ctrl_r, wr_req.data, wr_req.strb, power_mode_pkg::CTRL_MASK);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clksel_r <= power_mode_pkg::CLKSEL_RESET;
		end else if (wr_clksel) begin
			clksel_r <= merge_strb(clksel_r, wr_req.data, wr_req.strb,
				power_mode_pkg::CLKSEL_MASK);
		end
	end

	// ----------------------------------------
	// Wake detection
	// ----------------------------------------
	assign deep_req = ctrl_r[power_mode_pkg::CTRL_SLEEP_BIT] &&
		ctrl_r[power_mode_pkg::CTRL_DEEP_BIT];
	assign idle_wake = (mode_r == power_mode_pkg::MODE_IDLE) && (|irq_pending);
	assign deep_wake = (mode_r == power_mode_pkg::MODE_DEEP) && (|pd_wake_req);
	assign restart_busy = (mode_r == power_mode_pkg::MODE_WAKE);

	always_comb begin
		wake_set = '0;
		if (deep_wake) begin
			wake_set[power_mode_pkg::WAKE_SRC_N-1:0] = pd_wake_req;
		end
		wake_set[power_mode_pkg::WAKE_IRQ_BIT] = idle_wake;
	end

	always_comb begin
		wake_clr = '0;
		if (wr_wake && wr_req.strb[0]) begin
			wake_clr[power_mode_pkg::WAKE_SRC_N-1:0] = wr_req.data[power_mode_pkg::WAKE_SRC_N-1:0];
		end
		if (wr_wake && wr_req.strb[1]) begin
			wake_clr[power_mode_pkg::WAKE_IRQ_BIT] = wr_req.data[power_mode_pkg::WAKE_IRQ_BIT];
		end
	end

	// Set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_flag_r <= '0;
		end else begin
			wake_flag_r <= (wake_flag_r & ~wake_clr) | wake_set;
		end
	end

	// ----------------------------------------
	// Mode sequencer
	// ----------------------------------------
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			power_mode_pkg::MODE_RUN: begin
				if (wait_for_interrupt_instr) begin
					if (deep_req) begin
						mode_nxt = power_mode_pkg::MODE_DEEP;
					end else begin
						mode_nxt = power_mode_pkg::MODE_IDLE;
					end
				end
			end
			power_mode_pkg::MODE_IDLE: begin
				if (idle_wake) begin
					mode_nxt = power_mode_pkg::MODE_RUN;
				end
			end
			power_mode_pkg::MODE_DEEP: begin
				if (deep_wake) begin
					mode_nxt = power_mode_pkg::MODE_WAKE;
				end
			end
			power_mode_pkg::MODE_WAKE: begin
				if (settle_r == '0) begin
					mode_nxt = power_mode_pkg::MODE_RUN;
				end
			end
			default: begin
				mode_nxt = power_mode_pkg::MODE_RUN;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= power_mode_pkg::MODE_RUN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// ----------------------------------------
	// Restart counter
	// ----------------------------------------
	always_comb begin
		settle_nxt = settle_r;
		if (deep_wake) begin
			settle_nxt = power_mode_pkg::SETTLE_W'(power_mode_pkg::OSC_SETTLE_CYC - 1);
		end else if (restart_busy && settle_r != '0) begin
			settle_nxt = settle_r - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_r <= '0;
		end else begin
			settle_r <= settle_nxt;
		end
	end

	// ----------------------------------------
	// Clock gates
	// ----------------------------------------
	clock_gate_map u_map (
		.mode(mode_nxt),
		.slow_xtal_on(ctrl_r[power_mode_pkg::CTRL_SLOW_XTAL_BIT]),
		.slow_rc_on(ctrl_r[power_mode_pkg::CTRL_SLOW_RC_BIT]),
		.timer_src(clksel_r[power_mode_pkg::SEL_TIMER_LSB +: 2]),
		.watchdog_src(clksel_r[power_mode_pkg::SEL_WATCHDOG_LSB +: 2]),
		.pwm_src_slow_xtal(clksel_r[power_mode_pkg::SEL_PWM_BIT]),
		.gate(gate_nxt)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_r <= power_mode_pkg::GATE_ALL_ON;
		end else begin
			gate_r <= gate_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	assign clk_gate = gate_r;
	assign power_mode = mode_r;

endmodule

// *** power_mode_clock_gating_chk.sv ***
`timescale 1ns/100ps
module power_mode_clock_gating_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wait_for_interrupt_instr,
	input wire logic [31:0] irq_pending,
	input wire logic [power_mode_pkg::WAKE_SRC_N-1:0] pd_wake_req,
	input power_mode_pkg::mode_t power_mode,
	input power_mode_pkg::clk_gate_t clk_gate
);
	localparam int SETTLE_M1 = power_mode_pkg::OSC_SETTLE_CYC - 1;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Mode sequencing
	// ----------------------------------------
	property p_reset;
		$past(aresetn) == 1'b0 |-> power_mode == power_mode_pkg::MODE_RUN &&
			clk_gate == power_mode_pkg::GATE_ALL_ON;
	endproperty
	a_reset: assert property (p_reset) else $error("mode or gates wrong after reset");
	property p_enter;
		power_mode == power_mode_pkg::MODE_RUN && wait_for_interrupt_instr |=>
			power_mode inside {power_mode_pkg::MODE_IDLE, power_mode_pkg::MODE_DEEP};
	endproperty
	a_enter: assert property (p_enter) else $error("wait instruction did not sleep");
	property p_run_hold;
		power_mode == power_mode_pkg::MODE_RUN && !wait_for_interrupt_instr |=>
			power_mode == power_mode_pkg::MODE_RUN;
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("left run without request");
	property p_idle_wake;
		power_mode == power_mode_pkg::MODE_IDLE && |irq_pending |=> power_mode == power_mode_pkg::MODE_RUN;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");
	property p_deep_hold;
		power_mode == power_mode_pkg::MODE_DEEP && pd_wake_req == '0 |=>
			power_mode == power_mode_pkg::MODE_DEEP;
	endproperty
	a_deep_hold: assert property (p_deep_hold) else $error("deep left without source");
	property p_deep_wake;
		power_mode == power_mode_pkg::MODE_DEEP && |pd_wake_req |=> power_mode == power_mode_pkg::MODE_WAKE
			&& clk_gate.high_speed_crystal && clk_gate.high_speed_rc_osc && !clk_gate.core;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("deep wake restart wrong");
	property p_wake_len;
		$rose(power_mode == power_mode_pkg::MODE_WAKE) |-> ##SETTLE_M1
			power_mode == power_mode_pkg::MODE_WAKE ##1 power_mode == power_mode_pkg::MODE_RUN;
	endproperty
	a_wake_len: assert property (p_wake_len) else $error("restart length wrong");
	// ----------------------------------------
	// Gating per mode
	// ----------------------------------------
	property p_idle_gate;
		power_mode == power_mode_pkg::MODE_IDLE |-> clk_gate == 27'h7efffff;
	endproperty
	a_idle_gate: assert property (p_idle_gate) else $error("idle gates wrong");
	property p_deep_gate;
		power_mode == power_mode_pkg::MODE_DEEP |-> (clk_gate & 27'h67fc5ff) == 27'h0240000;
	endproperty
	a_deep_gate: assert property (p_deep_gate) else $error("deep fixed gates wrong");
	property p_deep_slow;
		power_mode == power_mode_pkg::MODE_DEEP |-> clk_gate.rtc == clk_gate.low_speed_crystal &&
			(!clk_gate.pwm || clk_gate.low_speed_crystal);
	endproperty
	a_deep_slow: assert property (p_deep_slow) else $error("rtc or pwm gate wrong");
	property p_deep_tmr;
		power_mode == power_mode_pkg::MODE_DEEP && (clk_gate.timer || clk_gate.watchdog_unit) |->
			clk_gate.low_speed_crystal || clk_gate.low_speed_rc_osc;
	endproperty
	a_deep_tmr: assert property (p_deep_tmr) else $error("timer gate wrong");
endmodule
bind power_mode_clock_gating power_mode_clock_gating_chk u_power_mode_clock_gating_chk (
	.aclk(aclk), .aresetn(aresetn), .wait_for_interrupt_instr(wait_for_interrupt_instr),
	.irq_pending(irq_pending), .pd_wake_req(pd_wake_req), .power_mode(power_mode),
	.clk_gate(clk_gate));

// *** power_mode_clock_gating_test.sv ***
`timescale 1ns/100ps
module power_mode_clock_gating_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, wait_instr;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, irq, rv;
	logic [7:0] pd;
	power_mode_pkg::mode_t power_mode;
	power_mode_pkg::clk_gate_t clk_gate;
	logic cmd_wait = 1'b0, cmd_wake = 1'b0, cmd_irq = 1'b0;
	logic [4:0] cmd_bit = 5'h00;
	logic [7:0] cmd_dly = 8'h00;
	int n_mismatch = 0;
	int num_checks = 0;
	typedef struct packed {logic [8:0] ctrl; logic [4:0] sel; logic deep;} row_t;
	row_t rows[11] = '{'{9'h183, 5'h05, 1'b1}, '{9'h182, 5'h0a, 1'b1}, '{9'h181, 5'h1a, 1'b1},
		'{9'h180, 5'h15, 1'b1}, '{9'h183, 5'h16, 1'b1}, '{9'h181, 5'h10, 1'b1},
		'{9'h182, 5'h19, 1'b1}, '{9'h183, 5'h00, 1'b1}, '{9'h000, 5'h00, 1'b0},
		'{9'h080, 5'h1f, 1'b0}, '{9'h100, 5'h05, 1'b0}};
	always #12.5 aclk = ~aclk;
	power_mode_clock_gating u_power_mode_clock_gating (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .wait_for_interrupt_instr(wait_instr),
		.irq_pending(irq), .pd_wake_req(pd), .power_mode(power_mode), .clk_gate(clk_gate));
	core_wake_model u_core_wake_model (.aclk(aclk), .aresetn(aresetn), .power_mode(power_mode),
		.cmd_wait(cmd_wait), .cmd_wake(cmd_wake), .cmd_irq(cmd_irq), .cmd_bit(cmd_bit),
		.cmd_dly(cmd_dly), .wait_for_interrupt_instr(wait_instr), .irq_pending(irq),
		.pd_wake_req(pd));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rr = bresp;
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rv = rdata;
		rr = rresp;
		@(posedge aclk);
	endtask
	task waitm(input logic [1:0] m);
		int n;
		n = 0;
		@(negedge aclk);
		while (power_mode !== m && n < 100) begin
			@(negedge aclk);
			n++;
		end
		@(posedge aclk);
		chk(32'(power_mode), 32'(m));
	endtask
	task wake(input logic i, input logic [4:0] b, input logic [7:0] d);
		cmd_wake <= 1'b1;
		cmd_irq <= i;
		cmd_bit <= b;
		cmd_dly <= d;
		@(posedge aclk);
		cmd_wake <= 1'b0;
	endtask
	function automatic power_mode_pkg::clk_gate_t dg(input logic [8:0] c, input logic [4:0] s);
		power_mode_pkg::clk_gate_t g;
		g = '0;
		g.regulator = 1'b1;
		g.sram_retention = 1'b1;
		g.low_speed_crystal = c[0];
		g.low_speed_rc_osc = c[1];
		g.timer = (s[1:0] == 2'h1 && c[0]) || (s[1:0] == 2'h2 && c[1]);
		g.watchdog_unit = (s[3:2] == 2'h1 && c[0]) || (s[3:2] == 2'h2 && c[1]);
		g.pwm = s[4] && c[0];
		g.rtc = c[0];
		return g;
	endfunction
	task nap(input logic deep, input logic [8:0] c, input logic [4:0] s);
		cmd_wait <= 1'b1;
		@(posedge aclk);
		cmd_wait <= 1'b0;
		waitm(deep ? 2'h3 : 2'h1);
		chk(32'(clk_gate), deep ? 32'(dg(c, s)) : 32'h07efffff);
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		#500000;
		n_mismatch++;
		results;
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'({power_mode, clk_gate}), 32'h07ffffff);
		rd(power_mode_pkg::CTRL_OFS);
		chk(rv, power_mode_pkg::CTRL_RESET);
		for (int i = 0; i < 11; i++) begin
			wr(power_mode_pkg::CTRL_OFS, 32'(rows[i].ctrl), 4'hf);
			wr(power_mode_pkg::CLKSEL_OFS, 32'(rows[i].sel), 4'hf);
			rd(power_mode_pkg::CTRL_OFS);
			chk(rv, 32'(rows[i].ctrl));
			rd(power_mode_pkg::CLKSEL_OFS);
			chk(rv, 32'(rows[i].sel));
			nap(rows[i].deep, rows[i].ctrl, rows[i].sel);
			wake(!rows[i].deep, 5'(i), 8'(i * 3));
			if (rows[i].deep) begin
				waitm(2'h2);
				chk(32'({clk_gate.high_speed_crystal, clk_gate.pll, clk_gate.core}), 32'h6);
				rd(power_mode_pkg::STATUS_OFS);
				chk(rv, 32'h6);
			end
			waitm(2'h0);
			chk(32'(clk_gate), 32'h07ffffff);
			rd(power_mode_pkg::WAKE_OFS);
			chk(rv, rows[i].deep ? 32'h1 << i : 32'h100);
			wr(power_mode_pkg::WAKE_OFS, 32'h1ff, 4'hf);
		end
		wr(power_mode_pkg::CTRL_OFS, 32'h183, 4'hf);
		wr(power_mode_pkg::CTRL_OFS, 32'h0, 4'h2);
		rd(power_mode_pkg::CTRL_OFS);
		chk(rv, 32'h83);
		nap(1'b0, 9'h083, 5'h05);
		wake(1'b0, 5'h03, 8'h00);
		repeat (6) @(posedge aclk);
		chk(32'(power_mode), 32'h1);
		wake(1'b1, 5'h00, 8'h00);
		waitm(2'h0);
		wr(8'h10, 32'hffffffff, 4'hf);
		chk(32'(rr), 32'h2);
		rd(8'h10);
		chk(rv | 32'(rr), 32'h2);
		wr(power_mode_pkg::CTRL_OFS, 32'h183, 4'hf);
		nap(1'b1, 9'h183, 5'h05);
		wake(1'b1, 5'h1f, 8'h00);
		cmd_wait <= 1'b1;
		@(posedge aclk);
		cmd_wait <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(32'(power_mode), 32'h3);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'({power_mode, clk_gate}), 32'h07ffffff);
		results;
	end
endmodule

// *** power_mode_pkg.sv ***
package power_mode_pkg;

	// ----------------------------------------
	// Modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_RUN = 2'h0,
		MODE_IDLE = 2'h1,
		MODE_DEEP = 2'h3,
		MODE_WAKE = 2'h2
	} mode_t;

	// ----------------------------------------
	// Clock and oscillator gates, 1 = running
	// ----------------------------------------
	typedef struct packed {
		logic high_speed_crystal;
		logic high_speed_rc_osc;
		logic low_speed_crystal;
		logic low_speed_rc_osc;
		logic pll;
		logic regulator;
		logic core;
		logic bus;
		logic sram_retention;
		logic flash;
		logic external_bus_unit;
		logic gpio;
		logic peripheral_dma_unit;
		logic timer;
		logic pwm;
		logic watchdog_unit;
		logic window_watchdog_unit;
		logic rtc;
		logic uart;
		logic smartcard_host;
		logic ps2;
		logic i2c;
		logic spi;
		logic i2s;
		logic usb;
		logic adc;
		logic analog_comparator_unit;
	} clk_gate_t;

	localparam clk_gate_t GATE_ALL_ON = '1;

	// ----------------------------------------
	// Register requests
	// ----------------------------------------
	localparam int ADDR_W = 8;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} wr_req_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
	} rd_req_t;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] CLKSEL_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] WAKE_OFS = 8'h0c;

	localparam int CTRL_SLOW_XTAL_BIT = 0;
	localparam int CTRL_SLOW_RC_BIT = 1;
	localparam int CTRL_DEEP_BIT = 7;
	localparam int CTRL_SLEEP_BIT = 8;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0183;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

	localparam int SEL_TIMER_LSB = 0;
	localparam int SEL_WATCHDOG_LSB = 2;
	localparam int SEL_PWM_BIT = 4;
	localparam logic [31:0] CLKSEL_MASK = 32'h0000_001f;
	localparam logic [31:0] CLKSEL_RESET = 32'h0000_0000;

	localparam logic [1:0] SRC_BUS = 2'h0;
	localparam logic [1:0] SRC_SLOW_XTAL = 2'h1;
	localparam logic [1:0] SRC_SLOW_RC = 2'h2;

	localparam int STAT_BUSY_BIT = 2;
	localparam int WAKE_SRC_N = 8;
	localparam int WAKE_IRQ_BIT = 8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int OSC_SETTLE_NS = 1000;
	localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 6;

endpackage
